// file: common/dtt_pkg.sv
package dtt_pkg;
  // register map, timer index 0 is the second timer, 1 the third
  localparam logic [7:0] ADDR_SEC_CTRL = 8'h14;
  localparam logic [7:0] ADDR_SEC_RLD_HI = 8'h15;
  localparam logic [7:0] ADDR_SEC_RLD_LO = 8'h16;
  localparam logic [7:0] ADDR_SEC_CNT_HI = 8'h17;
  localparam logic [7:0] ADDR_SEC_CNT_LO = 8'h18;
  localparam logic [7:0] ADDR_THD_CTRL = 8'h19;
  localparam logic [7:0] ADDR_THD_RLD_HI = 8'h1a;
  localparam logic [7:0] ADDR_THD_RLD_LO = 8'h1b;
  localparam logic [7:0] ADDR_THD_CNT_HI = 8'h1c;
  localparam logic [7:0] ADDR_THD_CNT_LO = 8'h1d;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h21;
  localparam logic [7:0] ADDR_CMD = 8'h22;
  localparam logic [1:0][7:0] ADDR_CTRL = {ADDR_THD_CTRL, ADDR_SEC_CTRL};
  localparam logic [1:0][7:0] ADDR_RLD_HI = {ADDR_THD_RLD_HI, ADDR_SEC_RLD_HI};
  localparam logic [1:0][7:0] ADDR_RLD_LO = {ADDR_THD_RLD_LO, ADDR_SEC_RLD_LO};
  localparam logic [1:0][7:0] ADDR_CNT_HI = {ADDR_THD_CNT_HI, ADDR_SEC_CNT_HI};
  localparam logic [1:0][7:0] ADDR_CNT_LO = {ADDR_THD_CNT_LO, ADDR_SEC_CNT_LO};
  // control field positions
  localparam int CTRL_STOP_RX_BIT = 7;
  localparam int CTRL_START_LSB = 4;
  localparam int CTRL_AUTO_BIT = 3;
  localparam int CTRL_CLK_LSB = 0;
  localparam logic [7:0] CTRL_WR_MASK = 8'hbb;
  // command register bits: start at 0..1, stop at 2..3
  localparam int CMD_STOP_LSB = 2;
  // divider rates in kHz, core clock period 4 ns
  localparam int ACC_W = 18;
  localparam logic [ACC_W:0] CORE_CLK_KHZ = 19'd250000;
  localparam logic [ACC_W:0] FAST_CLK_KHZ = 19'd13560;
  localparam logic [ACC_W:0] SLOW_CLK_KHZ = 19'd212;

  typedef enum logic [1:0] {
    START_NONE = 2'b00,
    START_TX_END = 2'b01,
    START_TRIM_NO_UF = 2'b10,
    START_TRIM_UF = 2'b11
  } dtt_start_type;

  typedef enum logic [1:0] {
    CLK_FAST = 2'b00,
    CLK_SLOW = 2'b01,
    CLK_FIRST_UF = 2'b10,
    CLK_OTHER_UF = 2'b11
  } dtt_clk_type;

  typedef enum logic {
    TMR_IDLE = 1'b0,
    TMR_COUNTING = 1'b1
  } dtt_run_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dtt_bus_type;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] reload;
    logic [15:0] count;
    dtt_run_type run;
    logic uflow;
  } dtt_timer_type;

  typedef struct packed {
    dtt_timer_type [1:0] tmr;
    logic [ACC_W-1:0] acc_fast;
    logic [ACC_W-1:0] acc_slow;
    logic tick_fast;
    logic tick_slow;
    logic [1:0] lfo_sync;
    logic lfo_prev;
    logic [1:0] status;
    logic [1:0] mask;
    logic [7:0] rdata;
    logic irq;
  } dtt_state_type;

  localparam dtt_state_type ST_RESET = '0;
endpackage

// file: rtl/dtt_timers.sv
`timescale 1ns/100ps
// Notes on behaviour
// - second timer low reload byte is read/write at 16h.
// - reload writes never touch a running count; used at next start.
// - third timer high reload byte read/write; full value loaded on start.
// - second timer count high byte readable at 17h.
// - second timer count low byte readable at 18h.
// - stop-on-reception bit stops third timer after first four received bits.
// - stop-on-reception ignored in both trimming start modes.
// - start field bits 5:4; 00 no auto start, 01 start on transmit end.
// - 10 trim without underflow, 11 trim with underflow, rising edge start/stop.
// - auto-restart bit 3 reloads and restarts at zero.
// - without auto-restart the timer stops at zero.
// - third timer underflow sets its interrupt flag.
// - clock field bits 1:0; 00 13.56 MHz, 01 212 kHz.
// - third timer clock 10 first timer underflow, 11 second timer underflow.
// - second timer loads sixteen-bit reload value on start.
// - second timer clock 11 third underflow, 10 first underflow.
module dtt_timers
  import dtt_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire dtt_bus_type bus_i,
  input wire logic tx_end_i,
  input wire logic rx_first4_i,
  input wire logic first_timer_uflow_i,
  input wire logic lfo_i,
  output logic [7:0] rdata_o,
  output logic irq_o,
  output logic sec_uflow_o,
  output logic thd_uflow_o
);

  dtt_state_type st_reg;
  dtt_state_type st_next;
  logic [1:0] start_v;
  logic [1:0] tick_v;
  logic [1:0] trim_v;
  logic lfo_rise;
  logic [ACC_W:0] fast_sum;
  logic [ACC_W:0] slow_sum;

  // pick the count enable from the clock field
  function automatic logic tick_sel(input logic [1:0] sel, input logic fast,
                                    input logic slow, input logic first_uf,
                                    input logic other_uf);
    logic t;
    t = 1'b0;
    case (dtt_clk_type'(sel))
      CLK_FAST: t = fast;
      CLK_SLOW: t = slow;
      CLK_FIRST_UF: t = first_uf;
      CLK_OTHER_UF: t = other_uf;
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  // whole next-state computation
  always_comb begin
    dtt_timer_type t;
    dtt_start_type ssel;
    logic stop_any;
    t = '0;
    ssel = START_NONE;
    stop_any = 1'b0;
    st_next = st_reg;
    start_v = 2'b00;
    tick_v = 2'b00;
    trim_v = 2'b00;

    // fractional dividers for the two fixed rates
    fast_sum = {1'b0, st_reg.acc_fast} + FAST_CLK_KHZ;
    slow_sum = {1'b0, st_reg.acc_slow} + SLOW_CLK_KHZ;
    st_next.tick_fast = (fast_sum >= CORE_CLK_KHZ);
    st_next.tick_slow = (slow_sum >= CORE_CLK_KHZ);
    if (st_next.tick_fast) begin
      fast_sum = fast_sum - CORE_CLK_KHZ;
    end
    if (st_next.tick_slow) begin
      slow_sum = slow_sum - CORE_CLK_KHZ;
    end
    st_next.acc_fast = fast_sum[ACC_W-1:0];
    st_next.acc_slow = slow_sum[ACC_W-1:0];

    // oscillator input crosses in through two flops
    st_next.lfo_sync = {st_reg.lfo_sync[0], lfo_i};
    st_next.lfo_prev = st_reg.lfo_sync[1];
    lfo_rise = st_reg.lfo_sync[1] & ~st_reg.lfo_prev;

    // per-timer control, start/stop and countdown
    for (int i = 0; i < 2; i++) begin
      t = st_reg.tmr[i];
      ssel = dtt_start_type'(t.ctrl[CTRL_START_LSB +: 2]);
      st_next.tmr[i].uflow = 1'b0;
      trim_v[i] = (ssel == START_TRIM_NO_UF) || (ssel == START_TRIM_UF);
      // underflow of the sibling timer as clock
      tick_v[i] = tick_sel(t.ctrl[CTRL_CLK_LSB +: 2], st_reg.tick_fast,
                           st_reg.tick_slow, first_timer_uflow_i,
                           st_reg.tmr[1-i].uflow);
      start_v[i] = ((ssel == START_TX_END) && tx_end_i) ||
                   (bus_i.wr && (bus_i.addr == ADDR_CMD) && bus_i.wdata[i]) ||
                   (trim_v[i] && lfo_rise && (t.run == TMR_IDLE));
      // stop on reception only outside trimming
      stop_any = (t.ctrl[CTRL_STOP_RX_BIT] && !trim_v[i] && rx_first4_i) ||
                 (trim_v[i] && lfo_rise && (t.run == TMR_COUNTING)) ||
                 (bus_i.wr && (bus_i.addr == ADDR_CMD) &&
                  bus_i.wdata[CMD_STOP_LSB + i]);
      if (start_v[i]) begin
        // load the full reload value held before this cycle
        st_next.tmr[i].count = t.reload;
        st_next.tmr[i].run = TMR_COUNTING;
      end else if (stop_any) begin
        st_next.tmr[i].run = TMR_IDLE;
      end else if ((t.run == TMR_COUNTING) && tick_v[i]) begin
        if (t.count != 16'h0000) begin
          st_next.tmr[i].count = t.count - 16'h0001;
        end else if (ssel != START_TRIM_NO_UF) begin
          st_next.tmr[i].uflow = 1'b1;
          if (t.ctrl[CTRL_AUTO_BIT]) begin
            st_next.tmr[i].count = t.reload;
          end else begin
            st_next.tmr[i].run = TMR_IDLE;
          end
        end
      end
      if (bus_i.wr && (bus_i.addr == ADDR_CTRL[i])) begin
        st_next.tmr[i].ctrl = bus_i.wdata & CTRL_WR_MASK;
      end
      // reload bytes only, never the count
      if (bus_i.wr && (bus_i.addr == ADDR_RLD_HI[i])) begin
        st_next.tmr[i].reload[15:8] = bus_i.wdata;
      end
      if (bus_i.wr && (bus_i.addr == ADDR_RLD_LO[i])) begin
        st_next.tmr[i].reload[7:0] = bus_i.wdata;
      end
    end

    // sticky flags, write one clears, a new event wins
    st_next.status = st_reg.status;
    if (bus_i.wr && (bus_i.addr == ADDR_IRQ_STAT)) begin
      st_next.status = st_reg.status & ~bus_i.wdata[1:0];
    end
    st_next.status = st_next.status |
                     {st_next.tmr[1].uflow, st_next.tmr[0].uflow};
    if (bus_i.wr && (bus_i.addr == ADDR_IRQ_MASK)) begin
      st_next.mask = bus_i.wdata[1:0];
    end
    st_next.irq = |(st_next.status & st_next.mask);

    // read data valid only the cycle after the strobe
    st_next.rdata = 8'h00;
    if (bus_i.rd) begin
      if (bus_i.addr == ADDR_SEC_CTRL) begin
        st_next.rdata = st_reg.tmr[0].ctrl;
      end else if (bus_i.addr == ADDR_SEC_RLD_HI) begin
        st_next.rdata = st_reg.tmr[0].reload[15:8];
      end else if (bus_i.addr == ADDR_SEC_RLD_LO) begin
        st_next.rdata = st_reg.tmr[0].reload[7:0];
      end else if (bus_i.addr == ADDR_SEC_CNT_HI) begin
        st_next.rdata = st_reg.tmr[0].count[15:8];
      end else if (bus_i.addr == ADDR_SEC_CNT_LO) begin
        st_next.rdata = st_reg.tmr[0].count[7:0];
      end else if (bus_i.addr == ADDR_THD_CTRL) begin
        st_next.rdata = st_reg.tmr[1].ctrl;
      end else if (bus_i.addr == ADDR_THD_RLD_HI) begin
        st_next.rdata = st_reg.tmr[1].reload[15:8];
      end else if (bus_i.addr == ADDR_THD_RLD_LO) begin
        st_next.rdata = st_reg.tmr[1].reload[7:0];
      end else if (bus_i.addr == ADDR_THD_CNT_HI) begin
        st_next.rdata = st_reg.tmr[1].count[15:8];
      end else if (bus_i.addr == ADDR_THD_CNT_LO) begin
        st_next.rdata = st_reg.tmr[1].count[7:0];
      end else if (bus_i.addr == ADDR_IRQ_STAT) begin
        st_next.rdata = {6'h00, st_reg.status};
      end else if (bus_i.addr == ADDR_IRQ_MASK) begin
        st_next.rdata = {6'h00, st_reg.mask};
      end else begin
        st_next.rdata = 8'h00; // unmapped and command read zero
      end
    end
  end

  // single state register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state flops
  assign rdata_o = st_reg.rdata;
  assign irq_o = st_reg.irq;
  assign sec_uflow_o = st_reg.tmr[0].uflow;
  assign thd_uflow_o = st_reg.tmr[1].uflow;

  default clocking dtt_cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  chk_reload_low_write: assert property (
    bus_i.wr && bus_i.addr == ADDR_SEC_RLD_LO
    |=> st_reg.tmr[0].reload[7:0] == $past(bus_i.wdata))
    else $error("second reload low byte not written");

  chk_reload_no_disturb: assert property (
    bus_i.wr && bus_i.addr == ADDR_THD_RLD_HI && !start_v[1] && !tick_v[1]
    && !$past(rst_i)
    |=> st_reg.tmr[1].count == $past(st_reg.tmr[1].count))
    else $error("reload write changed a count");

  chk_third_load: assert property (
    start_v[1] |=> st_reg.tmr[1].run == TMR_COUNTING &&
    st_reg.tmr[1].count == $past(st_reg.tmr[1].reload))
    else $error("third timer did not load reload value");

  chk_count_high_read: assert property (
    bus_i.rd && bus_i.addr == ADDR_SEC_CNT_HI
    |=> rdata_o == $past(st_reg.tmr[0].count[15:8]) ##1 (rdata_o == 8'h00
        || $past(bus_i.rd)))
    else $error("count high read wrong");

  chk_count_low_read: assert property (
    bus_i.rd && bus_i.addr == ADDR_SEC_CNT_LO
    |=> rdata_o == $past(st_reg.tmr[0].count[7:0]))
    else $error("count low read wrong");

  chk_stop_rx: assert property (
    st_reg.tmr[1].ctrl[CTRL_STOP_RX_BIT] && !trim_v[1] && rx_first4_i
    && !start_v[1] |=> st_reg.tmr[1].run == TMR_IDLE)
    else $error("third timer not stopped on reception");

  chk_trim_ignores_rx: assert property (
    trim_v[1] && rx_first4_i && st_reg.tmr[1].run == TMR_COUNTING && !lfo_rise
    && st_reg.tmr[1].count != 16'h0000
    && !(bus_i.wr && bus_i.addr == ADDR_CMD)
    |=> st_reg.tmr[1].run == TMR_COUNTING)
    else $error("stop on reception acted while trimming");

  chk_tx_start: assert property (
    st_reg.tmr[1].ctrl[5:4] == START_TX_END && tx_end_i
    |=> st_reg.tmr[1].run == TMR_COUNTING)
    else $error("third timer missed transmit end start");

  chk_restart: assert property (
    st_reg.tmr[1].run == TMR_COUNTING && tick_v[1] && !start_v[1]
    && st_reg.tmr[1].count == 16'h0000 && st_reg.tmr[1].ctrl[CTRL_AUTO_BIT]
    && st_reg.tmr[1].ctrl[5:4] != START_TRIM_NO_UF && !rx_first4_i
    && !lfo_rise && !(bus_i.wr && bus_i.addr == ADDR_CMD)
    |=> st_reg.tmr[1].run == TMR_COUNTING &&
    st_reg.tmr[1].count == $past(st_reg.tmr[1].reload) ##1 thd_uflow_o == 1'b0)
    else $error("auto restart failed");

  chk_flag_set: assert property (
    $rose(thd_uflow_o) |-> st_reg.status[1] ##1 !thd_uflow_o ||
    st_reg.tmr[1].ctrl[CTRL_AUTO_BIT])
    else $error("third underflow flag not set");

  chk_irq_level: assert property (
    st_reg.status[1] && st_reg.mask[1] && !(bus_i.wr && bus_i.addr == ADDR_IRQ_STAT)
    && !(bus_i.wr && bus_i.addr == ADDR_IRQ_MASK)
    |=> irq_o)
    else $error("interrupt not raised for masked-in flag");

  chk_sec_load: assert property (
    start_v[0] |=> st_reg.tmr[0].run == TMR_COUNTING &&
    st_reg.tmr[0].count == $past(st_reg.tmr[0].reload))
    else $error("second timer did not load reload value");

  // reserved bits stay clear in both controls
  chk_ctrl_reserved: assert property (
    st_reg.tmr[0].ctrl[6] == 1'b0 && st_reg.tmr[0].ctrl[2] == 1'b0 &&
    st_reg.tmr[1].ctrl[6] == 1'b0 && st_reg.tmr[1].ctrl[2] == 1'b0)
    else $error("reserved control bit set");

  // no auto-restart, underflow stops the timer
  chk_stop_at_zero: assert property (
    st_reg.tmr[0].run == TMR_COUNTING && tick_v[0] && !start_v[0]
    && st_reg.tmr[0].count == 16'h0000 && !st_reg.tmr[0].ctrl[CTRL_AUTO_BIT]
    && st_reg.tmr[0].ctrl[5:4] != START_TRIM_NO_UF
    |=> st_reg.tmr[0].run == TMR_IDLE)
    else $error("second timer kept running past zero");

  // trimming without underflow parks at zero silently
  chk_trim_hold: assert property (
    st_reg.tmr[1].ctrl[5:4] == START_TRIM_NO_UF && tick_v[1]
    && st_reg.tmr[1].run == TMR_COUNTING && st_reg.tmr[1].count == 16'h0000
    && !lfo_rise && !(bus_i.wr && bus_i.addr == ADDR_CMD)
    |=> !thd_uflow_o && st_reg.tmr[1].count == 16'h0000)
    else $error("trim without underflow produced an underflow");

  // one tick takes exactly one off the count
  chk_count_step: assert property (
    st_reg.tmr[1].run == TMR_COUNTING && tick_v[1] && !start_v[1]
    && st_reg.tmr[1].count != 16'h0000 && !lfo_rise && !rx_first4_i
    && !(bus_i.wr && bus_i.addr == ADDR_CMD)
    |=> st_reg.tmr[1].count == $past(st_reg.tmr[1].count) - 16'h0001)
    else $error("third timer count step wrong");

  // interrupt level always mirrors the unmasked flags
  chk_irq_mirror: assert property (
    irq_o == |(st_reg.status & st_reg.mask))
    else $error("interrupt level disagrees with flags");

  // read data idle at zero when no read was taken
  chk_rdata_idle: assert property (
    !$past(bus_i.rd) |-> rdata_o == 8'h00)
    else $error("read data not idle");

  // second timer clocked by third underflow
  chk_sec_uf_clock: assert property (
    st_reg.tmr[0].ctrl[1:0] == 2'b11 |-> tick_v[0] == st_reg.tmr[1].uflow)
    else $error("second timer clock source wrong");

  // third timer clocked by second underflow
  chk_thd_uf_clock: assert property (
    st_reg.tmr[1].ctrl[1:0] == 2'b11 |-> tick_v[1] == st_reg.tmr[0].uflow)
    else $error("third timer clock source wrong");

  // flag clears on a written one unless a new underflow lands
  chk_flag_clear: assert property (
    bus_i.wr && bus_i.addr == ADDR_IRQ_STAT && bus_i.wdata[1]
    |=> !st_reg.status[1] || thd_uflow_o)
    else $error("third underflow flag not cleared");

  // fast divider never ticks two cycles running
  chk_fast_rate: assert property (
    st_reg.tick_fast |=> !st_reg.tick_fast)
    else $error("fast divider ticks too often");

  // slow divider never ticks two cycles running
  chk_slow_rate: assert property (
    st_reg.tick_slow |=> !st_reg.tick_slow)
    else $error("slow divider ticks too often");

  // command stop halts the third timer
  chk_cmd_stop: assert property (
    bus_i.wr && bus_i.addr == ADDR_CMD && bus_i.wdata[CMD_STOP_LSB + 1]
    && !start_v[1] |=> st_reg.tmr[1].run == TMR_IDLE)
    else $error("third timer ignored stop command");

endmodule

// file: tb/dual_reload_countdown_timers_bench.sv
`timescale 1ns/100ps
module dual_reload_countdown_timers_bench;
  import dtt_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  dtt_bus_type bus = '0;
  logic tx_end = 1'b0;
  logic rx4 = 1'b0;
  logic fuf = 1'b0;
  logic low_frequency_oscillator = 1'b0;
  logic [7:0] rdata;
  logic irq;
  logic sec_uf;
  logic thd_uf;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  int n_sec = 0;
  int n_thd = 0;
  int m_cnt;
  logic [7:0] rd_val;
  logic [7:0] r_hi;
  logic [7:0] r_lo;

  dtt_timers u_dut (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .bus_i(bus),
    .tx_end_i(tx_end),
    .rx_first4_i(rx4),
    .first_timer_uflow_i(fuf),
    .lfo_i(low_frequency_oscillator),
    .rdata_o(rdata),
    .irq_o(irq),
    .sec_uflow_o(sec_uf),
    .thd_uflow_o(thd_uf)
  );

  // 250 mhz core clock
  always #2 core_clk_i = ~core_clk_i;

  // underflow pulses are one cycle wide, so each edge counts one once
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (sec_uf === 1'b1) n_sec <= n_sec + 1;
    if (thd_uf === 1'b1) n_thd <= n_thd + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle register write, a free cycle follows
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk_i) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i) bus <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk_i) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i) bus <= '0;
    #1 v = rdata;
  endtask

  task automatic rdc(string what, logic [7:0] a, logic [7:0] e);
    rd(a, rd_val);
    check(what, {8'h00, rd_val}, {8'h00, e});
  endtask

  // hi and lo are separate reads; only safe while no tick can land
  // never called while a reception pulse is in flight
  task automatic cnt(string what, int t, logic [15:0] e);
    rd(t != 0 ? ADDR_THD_CNT_HI : ADDR_SEC_CNT_HI, r_hi);
    rd(t != 0 ? ADDR_THD_CNT_LO : ADDR_SEC_CNT_LO, r_lo);
    check(what, {r_hi, r_lo}, e);
  endtask

  // one-cycle pulse: 0 first-timer underflow, 1 tx end, 2 rx first bits
  task automatic pulse(int k);
    @(posedge core_clk_i)
    case (k)
      0: fuf <= 1'b1;
      1: tx_end <= 1'b1;
      default: rx4 <= 1'b1;
    endcase
    @(posedge core_clk_i) {fuf, tx_end, rx4} <= 3'b000;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // main sequence
  initial begin
    void'($urandom(32));
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rdc("sec rld lo rst", ADDR_SEC_RLD_LO, 8'h00);
    rdc("thd ctrl rst", ADDR_THD_CTRL, 8'h00);
    m_cnt = $urandom;
    wr(ADDR_SEC_RLD_LO, m_cnt[7:0]);
    wr(ADDR_THD_RLD_HI, m_cnt[15:8]);
    rdc("sec rld lo", ADDR_SEC_RLD_LO, m_cnt[7:0]);
    rdc("thd rld hi", ADDR_THD_RLD_HI, m_cnt[15:8]);
    wr(ADDR_THD_CTRL, 8'hff);
    rdc("thd ctrl", ADDR_THD_CTRL, 8'hbb);
    rdc("unmapped", 8'h3f, 8'h00);
    // second timer on first-timer underflow, third on second's underflow
    wr(ADDR_SEC_CTRL, 8'h02);
    wr(ADDR_SEC_RLD_HI, 8'h01);
    wr(ADDR_SEC_RLD_LO, 8'h03);
    wr(ADDR_THD_CTRL, 8'h03);
    wr(ADDR_THD_RLD_LO, 8'h05);
    wr(ADDR_THD_RLD_HI, 8'h00);
    wr(ADDR_CMD, 8'h03);
    cnt("sec start", 0, 16'h0103);
    wr(ADDR_SEC_RLD_LO, 8'h09);
    pulse(0);
    cnt("sec run", 0, 16'h0102);
    repeat (259) pulse(0);
    pulse(0);
    cnt("sec stop", 0, 16'h0000);
    check("sec uflow", 16'(n_sec), 16'd1);
    cnt("thd by sec", 1, 16'h0004);
    wr(ADDR_CMD, 8'h01);
    cnt("sec new rld", 0, 16'h0109);
    // third timer: start on tx end, auto-restart, masked irq
    wr(ADDR_THD_RLD_LO, 8'h02);
    wr(ADDR_THD_CTRL, 8'h1a);
    pulse(1);
    cnt("thd tx start", 1, 16'h0002);
    repeat (3) pulse(0);
    cnt("thd restart", 1, 16'h0002);
    check("thd uflow", 16'(n_thd), 16'd1);
    check("irq masked", {15'h0000, irq}, 16'h0000);
    rdc("irq status", ADDR_IRQ_STAT, 8'h03);
    wr(ADDR_IRQ_MASK, 8'h02);
    repeat (2) @(posedge core_clk_i);
    #1 check("irq on", {15'h0000, irq}, 16'h0001);
    wr(ADDR_IRQ_STAT, 8'h02);
    repeat (2) @(posedge core_clk_i);
    #1 check("irq clr", {15'h0000, irq}, 16'h0000);
    // stop after the first received bits
    wr(ADDR_THD_CTRL, 8'h9a);
    pulse(1);
    pulse(2);
    pulse(0);
    cnt("thd rx stop", 1, 16'h0002);
    // trimming: lfo edges start and stop, reception stop ignored
    wr(ADDR_THD_CTRL, 8'ha2);
    @(posedge core_clk_i) low_frequency_oscillator <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    pulse(2);
    pulse(0);
    cnt("thd trim run", 1, 16'h0001);
    @(posedge core_clk_i) low_frequency_oscillator <= 1'b0;
    repeat (5) @(posedge core_clk_i);
    low_frequency_oscillator <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    pulse(0);
    cnt("thd trim stop", 1, 16'h0001);
    wr(ADDR_THD_CTRL, 8'h02);
    pulse(1);
    pulse(0);
    cnt("thd no start", 1, 16'h0001);
    // second timer clocked by the third timer's underflow
    wr(ADDR_SEC_CTRL, 8'h03);
    wr(ADDR_CMD, 8'h03);
    repeat (3) pulse(0);
    cnt("sec by thd", 0, 16'h0108);
    check("thd uflow 2", 16'(n_thd), 16'd2);
    // fixed rates, tolerance covers divider jitter and read cycles
    wr(ADDR_THD_RLD_LO, 8'h80);
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_THD_CTRL, 8'(k));
      wr(ADDR_CMD, 8'h02);
      repeat (k != 0 ? 2360 : 184) @(posedge core_clk_i);
      rd(ADDR_THD_CNT_LO, r_lo);
      m_cnt = 128 - int'(r_lo);
      check("rate", 16'(m_cnt >= (k != 0 ? 1 : 8) && m_cnt <= (k != 0 ? 3 : 12)), 16'd1);
    end
    tally_and_finish();
  end
endmodule
